// File: hw/spicc_pkg.sv
// Constants for the serial unit control/configuration block.
// Assumes one core clock; all offsets are byte addresses on the plain register port.
package spicc_pkg;

  // Register offsets
  localparam logic [7:0]  CTRL_A_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h10;
  localparam logic [7:0]  MATCH_OFS       = 8'h14;
  localparam logic [7:0]  DATA_OFS        = 8'h18;
  localparam logic [7:0]  SYNC_OFS        = 8'h1C;

  // Control A field positions
  localparam int          SOFT_RESET_BIT  = 0;
  localparam int          ENABLE_BIT      = 1;
  localparam int          MODE_LSB        = 2;
  localparam int          KEEP_RUN_BIT    = 7;
  localparam int          NOTIFY_BIT      = 8;
  localparam int          OUT_PAD_LSB     = 16;
  localparam int          IN_PAD_LSB      = 20;
  localparam int          FRAME_FORMAT_LSB        = 24;
  localparam int          PHASE_BIT       = 28;
  localparam int          IDLE_BIT        = 29;
  localparam int          ORDER_BIT       = 30;
  localparam logic [31:0] CTRL_A_WMASK    = 32'h7F33_019C;
  localparam logic [31:0] CTRL_A_RESET    = 32'h0000_0000;

  // Status and sync field positions
  localparam int          OVF_BIT         = 2;
  localparam int          BUSY_BIT        = 3;
  localparam int          SYNC_SR_BIT     = 0;
  localparam int          SYNC_EN_BIT     = 1;

  // Encodings
  localparam logic [2:0]  MODE_SLAVE      = 3'h2;
  localparam logic [2:0]  MODE_MASTER     = 3'h3;
  localparam logic [3:0]  FRAME_FORMAT_PLAIN      = 4'h0;
  localparam logic [3:0]  FRAME_FORMAT_ADDR       = 4'h2;
  localparam logic [7:0]  MATCH_RESET     = 8'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;

  // Timing counts in core clock cycles and character length in bits
  localparam int          SCK_HALF_CYCLES = 4;
  localparam int          SYNC_DIV_CYCLES = 4;
  localparam int          CHAR_BITS       = 8;

  typedef enum logic [1:0] {
    SPICC_IDLE   = 2'b00,
    SPICC_ACTIVE = 2'b01,
    SPICC_SKIP   = 2'b11
  } spicc_state_t;

endpackage

// File: hw/spicc_top.sv
// Control register, pad mapping and minimal shift engine of a serial unit
// acting as SPI master or slave.
// Assumes pads arrive asynchronously; sleep_req comes from core_clk logic.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module spicc_top #(
  parameter int SCK_HALF = spicc_pkg::SCK_HALF_CYCLES,
  parameter int SYNC_DIV = spicc_pkg::SYNC_DIV_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [3:0]  pad_in,
  output logic      [3:0]  pad_out,
  output logic      [3:0]  pad_oe_n,
  input  wire logic        sleep_req,
  output logic             gclk_run,
  output logic             wake_req
);

  generate
    if (SCK_HALF < 1 || SCK_HALF > 65535 || SYNC_DIV < 1 || SYNC_DIV > 255) begin : g_bad
      $error("spicc_top: divider parameter out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pad map decoding

  function automatic logic [1:0] dout_pad(input logic [1:0] sel);
    case (sel)
      2'h0:    dout_pad = 2'h0;
      2'h1:    dout_pad = 2'h2;
      2'h2:    dout_pad = 2'h3;
      default: dout_pad = 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] sck_pad(input logic [1:0] sel);
    case (sel)
      2'h0:    sck_pad = 2'h1;
      2'h1:    sck_pad = 2'h3;
      2'h2:    sck_pad = 2'h1;
      default: sck_pad = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] ss_pad(input logic [1:0] sel);
    ss_pad = sel[0] ? 2'h1 : 2'h2;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State declarations

  logic [31:0]             ctrl_reg;
  logic [7:0]              match_reg;
  logic [7:0]              tx_data_reg;
  logic                    tx_pend_reg;
  logic [7:0]              rx_data_reg;
  logic                    rx_valid_reg;
  logic                    ovf_flag_reg;
  logic                    ovf_pend_reg;
  logic                    pend_en_reg;
  logic                    pend_sr_reg;
  logic                    req_tgl_reg;
  logic                    ack_b1_reg;
  logic                    ack_b2_reg;
  logic                    req_p1_reg;
  logic                    req_p2_reg;
  logic                    ack_tgl_reg;
  logic                    en_active_reg;
  logic [7:0]              sync_cnt_reg;
  logic [3:0]              pin_s1_reg;
  logic [3:0]              pin_s2_reg;
  logic [3:0]              pin_s3_reg;
  spicc_pkg::spicc_state_t state_reg;
  spicc_pkg::spicc_state_t state_next;
  logic [7:0]              tx_sh_reg;
  logic [7:0]              rx_sh_reg;
  logic [3:0]              bit_cnt_reg;
  logic                    first_reg;
  logic                    sck_lvl_reg;
  logic [15:0]             half_cnt_reg;
  logic [4:0]              edge_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Field and strobe decoding

  wire       wr_ctrl    = reg_wr && reg_addr == spicc_pkg::CTRL_A_OFS;
  wire       wr_status  = reg_wr && reg_addr == spicc_pkg::STATUS_OFS;
  wire       wr_match   = reg_wr && reg_addr == spicc_pkg::MATCH_OFS;
  wire       wr_data    = reg_wr && reg_addr == spicc_pkg::DATA_OFS;
  wire       rx_read    = reg_rd && reg_addr == spicc_pkg::DATA_OFS;
  wire [2:0] mode       = ctrl_reg[spicc_pkg::MODE_LSB +: 3];
  wire       is_master  = mode == spicc_pkg::MODE_MASTER;
  wire       is_slave   = mode == spicc_pkg::MODE_SLAVE;
  wire       keep_run   = ctrl_reg[spicc_pkg::KEEP_RUN_BIT];
  wire       notify_now = ctrl_reg[spicc_pkg::NOTIFY_BIT];
  wire [1:0] out_sel    = ctrl_reg[spicc_pkg::OUT_PAD_LSB +: 2];
  wire [1:0] in_sel     = ctrl_reg[spicc_pkg::IN_PAD_LSB +: 2];
  wire [3:0] frame_format       = ctrl_reg[spicc_pkg::FRAME_FORMAT_LSB +: 4];
  wire       clock_sample_phase       = ctrl_reg[spicc_pkg::PHASE_BIT];
  wire       clock_idle_level       = ctrl_reg[spicc_pkg::IDLE_BIT];
  wire       lsb_first  = ctrl_reg[spicc_pkg::ORDER_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control register write path

  // protection covers both the written bit and the applied state
  wire        protect    = ctrl_reg[spicc_pkg::ENABLE_BIT] | en_active_reg;
  wire [31:0] prot_field = protect ? (ctrl_reg & spicc_pkg::CTRL_A_WMASK)
                                   : (reg_wdata & spicc_pkg::CTRL_A_WMASK);
  // enable stays writable; ignored only while a sync is in flight
  wire        en_bit     = pend_en_reg ? ctrl_reg[spicc_pkg::ENABLE_BIT]
                                       : reg_wdata[spicc_pkg::ENABLE_BIT];
  // soft reset wins over every other field of the same write
  wire        sr_write   = wr_ctrl && !pend_sr_reg && reg_wdata[spicc_pkg::SOFT_RESET_BIT];
  // only enable and soft reset writes raise a pending flag
  wire        en_write   = wr_ctrl && !pend_sr_reg && !sr_write && !pend_en_reg &&
                           (reg_wdata[spicc_pkg::ENABLE_BIT] != ctrl_reg[spicc_pkg::ENABLE_BIT]);
  wire        sync_done  = (pend_en_reg | pend_sr_reg) && ack_b2_reg == req_tgl_reg;
  wire [31:0] ctrl_next  = sr_write ? (spicc_pkg::CTRL_A_RESET | 32'h0000_0001)
                         : (wr_ctrl && !pend_sr_reg)
                           ? (prot_field | {30'h0, en_bit, 1'b0}) : ctrl_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst || (sync_done && pend_sr_reg)) begin
      ctrl_reg    <= spicc_pkg::CTRL_A_RESET;
      match_reg   <= spicc_pkg::MATCH_RESET;
      tx_data_reg <= spicc_pkg::DATA_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_match && !protect && !pend_sr_reg) begin
        match_reg <= reg_wdata[7:0];
      end
      if (wr_data && !pend_sr_reg) begin
        tx_data_reg <= reg_wdata[7:0];
      end
    end
  end

  // pending raised on write, cleared by returning acknowledge
  // soft reset bit and its pending flag drop in the same cycle
  // request toggles when no crossing is in flight, or on a soft reset write during an enable sync
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend_en_reg <= 1'b0;
      pend_sr_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      ack_b1_reg  <= 1'b0;
      ack_b2_reg  <= 1'b0;
    end else begin
      ack_b1_reg <= ack_tgl_reg;
      ack_b2_reg <= ack_b1_reg;
      if (sr_write || en_write) begin
        pend_sr_reg <= sr_write;
        pend_en_reg <= en_write;
        req_tgl_reg <= ~req_tgl_reg;
      end else if (sync_done) begin
        pend_sr_reg <= 1'b0;
        pend_en_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral side of the crossing, paced by a divider tick

  wire periph_tick = sync_cnt_reg == 8'(SYNC_DIV - 1);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_cnt_reg  <= 8'h00;
      req_p1_reg    <= 1'b0;
      req_p2_reg    <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      en_active_reg <= 1'b0;
    end else begin
      sync_cnt_reg <= periph_tick ? 8'h00 : sync_cnt_reg + 8'h01;
      if (periph_tick) begin
        req_p1_reg <= req_tgl_reg;
        req_p2_reg <= req_p1_reg;
        if (req_p2_reg != ack_tgl_reg) begin
          en_active_reg <= ctrl_reg[spicc_pkg::ENABLE_BIT] & !pend_sr_reg;
          ack_tgl_reg   <= req_p2_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad synchronisers and link edge detection

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_s1_reg <= 4'hF;
      pin_s2_reg <= 4'hF;
      pin_s3_reg <= 4'hF;
    end else begin
      pin_s1_reg <= pad_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  wire [1:0] do_idx  = dout_pad(out_sel);
  wire [1:0] sck_idx = sck_pad(out_sel);
  // slave select pad is read only in slave operation
  wire [1:0] ss_idx  = ss_pad(out_sel);
  // data input routed from the selected pad
  wire       din     = pin_s2_reg[in_sel];
  wire       ss_n    = is_slave ? pin_s2_reg[ss_idx] : 1'b1;
  wire       ss_fall = is_slave && pin_s3_reg[ss_idx] && !pin_s2_reg[ss_idx];
  wire       sck_s   = pin_s2_reg[sck_idx];
  wire       run     = en_active_reg && state_reg != spicc_pkg::SPICC_IDLE;

  wire m_edge   = run && is_master && half_cnt_reg == 16'(SCK_HALF - 1);
  wire s_edge   = run && is_slave && !ss_n && sck_s != pin_s3_reg[sck_idx];
  wire edge_evt = m_edge | s_edge;
  wire new_lvl  = is_master ? ~sck_lvl_reg : sck_s;
  // leading edge is the one leaving the idle level
  wire lead     = new_lvl != clock_idle_level;
  // phase picks which edge samples and which changes
  wire sample   = edge_evt && (lead ^ clock_sample_phase);
  wire change   = edge_evt && !(lead ^ clock_sample_phase);
  wire char_end = sample && bit_cnt_reg == 4'(spicc_pkg::CHAR_BITS - 1);
  wire [7:0] rx_shift = lsb_first ? {din, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], din};
  wire [7:0] tx_shift = lsb_first ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
  wire       tx_bit   = lsb_first ? tx_sh_reg[0] : tx_sh_reg[7];

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing

  // slave without standby run drops reception in sleep
  wire drop_rx  = is_slave && sleep_req && !keep_run;
  // master without standby run starts nothing new in sleep
  wire m_start  = en_active_reg && is_master && tx_pend_reg &&
                  state_reg == spicc_pkg::SPICC_IDLE && !(sleep_req && !keep_run);
  wire s_start  = en_active_reg && ss_fall && !drop_rx;
  wire m_finish = m_edge && edge_cnt_reg == 5'(2 * spicc_pkg::CHAR_BITS - 1);
  // addressed frames only in slave with format 0x2
  wire addr_chr = is_slave && frame_format == spicc_pkg::FRAME_FORMAT_ADDR && first_reg;
  // first byte of an addressed frame checked against match register
  wire addr_ok  = rx_shift == match_reg;
  wire deliver  = char_end && state_reg == spicc_pkg::SPICC_ACTIVE && !addr_chr;
  wire char_evt = char_end && state_reg == spicc_pkg::SPICC_ACTIVE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spicc_pkg::SPICC_IDLE: begin
        if (m_start || s_start) begin
          state_next = spicc_pkg::SPICC_ACTIVE;
        end
      end
      spicc_pkg::SPICC_ACTIVE: begin
        if (char_end && addr_chr && !addr_ok) begin
          state_next = spicc_pkg::SPICC_SKIP;
        end
      end
      spicc_pkg::SPICC_SKIP: begin
        state_next = spicc_pkg::SPICC_SKIP;
      end
      default: begin
        state_next = spicc_pkg::SPICC_IDLE;
      end
    endcase
    if (!en_active_reg || drop_rx || m_finish || (is_slave && ss_n)) begin
      state_next = spicc_pkg::SPICC_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg    <= spicc_pkg::SPICC_IDLE;
      sck_lvl_reg  <= 1'b0;
      half_cnt_reg <= 16'h0000;
      edge_cnt_reg <= 5'h00;
    end else begin
      state_reg    <= state_next;
      sck_lvl_reg  <= run && is_master ? (m_edge ? ~sck_lvl_reg : sck_lvl_reg) : clock_idle_level;
      half_cnt_reg <= (!run || m_edge) ? 16'h0000 : half_cnt_reg + 16'h0001;
      edge_cnt_reg <= !run ? 5'h00 : edge_cnt_reg + 5'(m_edge);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_sh_reg   <= 8'h00;
      rx_sh_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      first_reg   <= 1'b0;
    end else if (m_start || s_start || (char_end && is_slave)) begin
      tx_sh_reg   <= tx_data_reg;
      rx_sh_reg   <= rx_shift;
      bit_cnt_reg <= 4'h0;
      first_reg   <= !char_end;
    end else begin
      // Shift only after a bit was sampled so phase one keeps its first bit
      if (change && bit_cnt_reg != 4'h0) begin
        tx_sh_reg <= tx_shift;
      end
      if (sample) begin
        rx_sh_reg   <= rx_shift;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding, receive buffer and overflow

  wire ovf_evt = deliver && rx_valid_reg && !rx_read;
  // immediate mode flags at once; stream mode when prior data is read
  wire ovf_set = notify_now ? ovf_evt : (ovf_pend_reg && rx_read);
  wire ovf_clr = wr_status && reg_wdata[spicc_pkg::OVF_BIT];

  always_ff @(posedge core_clk) begin
    if (!nrst || (sync_done && pend_sr_reg)) begin
      tx_pend_reg  <= 1'b0;
      rx_data_reg  <= spicc_pkg::DATA_RESET;
      rx_valid_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
    end else begin
      tx_pend_reg  <= (wr_data && !pend_sr_reg) || (tx_pend_reg && !m_start);
      rx_valid_reg <= deliver || (rx_valid_reg && !rx_read);
      if (deliver && !ovf_evt) begin
        rx_data_reg <= rx_shift;
      end
      // Set wins over a clear in the same cycle
      ovf_flag_reg <= ovf_set || (ovf_flag_reg && !ovf_clr);
      ovf_pend_reg <= (ovf_evt && !notify_now) || (ovf_pend_reg && !rx_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pads, sleep handshake and register read

  // data out, clock and select placed by output pad select
  // master leaves the select pad undriven
  wire drv_do  = en_active_reg && (is_master || (is_slave && run && !ss_n));
  wire drv_sck = en_active_reg && is_master;
  logic [3:0] pad_out_next;
  logic [3:0] pad_oe_n_next;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pad
      wire is_do  = do_idx == 2'(gi);
      wire is_sck = sck_idx == 2'(gi);
      assign pad_out_next[gi]  = is_do ? tx_bit : (is_sck && sck_lvl_reg);
      assign pad_oe_n_next[gi] = !((is_do && drv_do) || (is_sck && drv_sck));
    end
  endgenerate

  // slave in standby wakes on receive done
  // master events wake the system in either setting
  wire wake_next = sleep_req && char_evt && (is_master || keep_run);
  // master clock gated only once its transaction has ended
  // standby run keeps the clock request up
  wire gclk_next = keep_run || !sleep_req || (is_master && run);

  wire [31:0] status_word = {28'h0, run, ovf_flag_reg, 1'b0, rx_valid_reg};
  wire [31:0] sync_word   = {30'h0, pend_en_reg, pend_sr_reg};
  wire [31:0] rd_word     = reg_addr == spicc_pkg::CTRL_A_OFS ? ctrl_reg
                          : reg_addr == spicc_pkg::STATUS_OFS ? status_word
                          : reg_addr == spicc_pkg::MATCH_OFS  ? {24'h0, match_reg}
                          : reg_addr == spicc_pkg::DATA_OFS   ? {24'h0, rx_data_reg}
                          : reg_addr == spicc_pkg::SYNC_OFS   ? sync_word : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
      pad_out   <= 4'h0;
      pad_oe_n  <= 4'hF;
      gclk_run  <= 1'b1;
      wake_req  <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
      pad_out   <= pad_out_next;
      pad_oe_n  <= pad_oe_n_next;
      gclk_run  <= gclk_next;
      wake_req  <= wake_next;
    end
  end

endmodule

`default_nettype wire

// File: tb/spicc_slave_model.sv
// Far-side serial slave: follows the clock pad, shifts one byte each way.
// Assumes core_clk oversamples the link clock; select comes from a GPIO.
`timescale 1ns/1ns
`default_nettype none
module spicc_slave_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] pad_out,
  input  wire logic [1:0] sck_idx,
  input  wire logic [1:0] do_idx,
  input  wire logic [1:0] in_idx,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsb_first,
  input  wire logic       frame_start,
  input  wire logic [7:0] tx_byte,
  output logic      [3:0] pad_in,
  output logic      [7:0] rx_byte = 8'h00,
  output int              bits = 0
);
  logic sck_q = 1'b0;
  logic miso  = 1'b0;
  wire  sck   = pad_out[sck_idx];
  wire  din   = pad_out[do_idx];
  always @(posedge core_clk) begin
    sck_q <= sck;
    if (frame_start) begin
      bits <= 0;
      miso <= lsb_first ? tx_byte[0] : tx_byte[7];
    end else if (sck != sck_q) begin
      if (sck == (clock_idle_level ^ ~clock_sample_phase)) begin
        rx_byte <= lsb_first ? {din, rx_byte[7:1]} : {rx_byte[6:0], din};
        bits    <= bits + 1;
      end else if (bits < 8) begin
        miso <= lsb_first ? tx_byte[bits] : tx_byte[7 - bits];
      end
    end
  end
  // Other pads show the inverse, so a wrong input select is caught
  always_comb begin
    pad_in         = {4{~miso}};
    pad_in[in_idx] = miso;
  end
endmodule
`default_nettype wire

// File: tb/spicc_top_monitor.sv
// Port checker for the serial unit control block.
// Assumes it is bound to spicc_top and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module spicc_top_monitor (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0]  pad_in,
  input wire logic [3:0]  pad_out,
  input wire logic [3:0]  pad_oe_n,
  input wire logic        sleep_req,
  input wire logic        gclk_run,
  input wire logic        wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == spicc_pkg::CTRL_A_OFS;
  wire mapped = reg_addr inside {8'h00, 8'h10, 8'h14, 8'h18, 8'h1C};
  ////////////////////////////////////////////////////////////////////
  a_rdata_after_read: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its cycle");
  a_unmapped_read_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_override:
    assert property (ctl_wr && reg_wdata[0] ##1 reg_rd && reg_addr == 8'h00
      |=> reg_rdata == 32'h0000_0001) else $error("soft reset kept other fields");
  a_enable_pending:
    assert property (ctl_wr && !reg_wdata[0] && reg_wdata[1] ##1 reg_rd && reg_addr == 8'h1C
      |=> reg_rdata[1] || reg_rdata[0]) else $error("enable write left no pending flag");
  a_wake_one_cycle:
    assert property (wake_req |=> !wake_req) else $error("wake pulse too long");
  a_wake_in_sleep:
    assert property (wake_req |-> $past(sleep_req)) else $error("wake without sleep");
  a_clock_awake:
    assert property ($past(!sleep_req) |-> gclk_run) else $error("clock stopped while awake");
  a_reset_pads: assert property ($rose(nrst) |-> pad_oe_n == 4'hF && !wake_req && gclk_run)
    else $error("outputs wrong after reset");
  c_wake: cover property (wake_req);
  c_sleep_stop: cover property (sleep_req && !gclk_run);
  c_pending: cover property (reg_rd && reg_addr == 8'h1C ##1 reg_rdata[1]);
endmodule
bind spicc_top spicc_top_monitor u_mon (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .sleep_req(sleep_req),
  .gclk_run(gclk_run), .wake_req(wake_req)
);
`default_nettype wire

// File: tb/spicc_top_tb.sv
// Bench: master transfers in all four modes, protection, overflow timing,
// sleep behaviour and soft reset. Assumes the far-side slave model.
`timescale 1ns/1ns
`default_nettype none
module spicc_top_tb;
  localparam logic [7:0] SCK_MAP = 8'hDD;
  localparam logic [7:0] DO_MAP  = 8'h38;
  localparam logic [7:0] SS_MAP  = 8'h66;
  logic        core_clk    = 1'b0;
  logic        nrst        = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        sleep_req   = 1'b0;
  logic        clock_idle_level        = 1'b0;
  logic        clock_sample_phase        = 1'b0;
  logic        lsb         = 1'b0;
  logic [1:0]  out_map     = 2'h0;
  logic        frame_start = 1'b0;
  logic [7:0]  tx_byte     = 8'h00;
  logic        woke        = 1'b0;
  int          err_count   = 0;
  int          checks      = 0;
  logic [31:0] reg_rdata;
  logic [3:0]  pad_in;
  logic [3:0]  pad_out;
  logic [3:0]  pad_oe_n;
  logic        gclk_run;
  logic        wake_req;
  logic [7:0]  rx_byte;
  int          bits;
  wire  [1:0]  sck_i = SCK_MAP[2*out_map +: 2];
  wire  [1:0]  do_i  = DO_MAP[2*out_map +: 2];
  wire  [1:0]  ss_i  = SS_MAP[2*out_map +: 2];
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (wake_req === 1'b1) woke <= 1'b1;
  // Half period of 8 cycles gives the 160 ns link clock
  spicc_top #(.SCK_HALF(8), .SYNC_DIV(2)) dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .sleep_req(sleep_req),
    .gclk_run(gclk_run), .wake_req(wake_req));
  spicc_slave_model u_far (
    .core_clk(core_clk), .pad_out(pad_out), .sck_idx(sck_i), .do_idx(do_i),
    .in_idx(ss_i), .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsb_first(lsb),
    .frame_start(frame_start), .tx_byte(tx_byte), .pad_in(pad_in),
    .rx_byte(rx_byte), .bits(bits));
  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_sync();
    logic [31:0] d;
    d = 32'hFFFF_FFFF;
    for (int k = 0; k < 100 && d !== 32'h0; k++) rd(spicc_pkg::SYNC_OFS, d);
    chk(d, 32'h0);
  endtask
  task automatic xfer(input logic [7:0] mosi, input logic [7:0] back);
    logic [31:0] d;
    tx_byte     <= back;
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    #1;
    wr(spicc_pkg::DATA_OFS, {24'h0, mosi});
    for (int k = 0; k < 400 && bits != 8; k++) @(posedge core_clk);
    #1;
    d = 32'h8;
    for (int k = 0; k < 50 && d[spicc_pkg::BUSY_BIT] !== 1'b0; k++) rd(8'h10, d);
    chk({24'h0, rx_byte}, {24'h0, mosi});
    chk(32'(pad_out[sck_i]), 32'(clock_idle_level));
    chk(32'(pad_oe_n[do_i]), 32'h0);
    chk(32'(pad_oe_n[ss_i]), 32'h1);
  endtask
  task automatic run_mode(input logic [1:0] m);
    logic [31:0] cfg;
    logic [31:0] d;
    logic [7:0]  b;
    b    = 8'hC3 ^ {6'h0, m};
    clock_idle_level <= m[1];
    clock_sample_phase <= m[0];
    lsb  <= ~m[0];
    out_map <= m;
    // Mode field 0x3 selects master, as software must program it
    cfg = {1'b0, ~m[0], m[1], m[0], 2'b0, m[0], 1'b0, 2'b0, SS_MAP[2*m +: 2], 2'b0, m,
           7'h0, m[0], m[1], 2'b0, spicc_pkg::MODE_MASTER, 2'b0};
    wr(8'h00, cfg);
    rd(8'h00, d);
    chk(d, cfg);
    rd(spicc_pkg::SYNC_OFS, d);
    chk(d, 32'h0);
    wr(8'h00, cfg | 32'h2);
    rd(spicc_pkg::SYNC_OFS, d);
    chk(32'(d[spicc_pkg::SYNC_EN_BIT]), 32'h1);
    rd(8'h00, d);
    chk(d, cfg | 32'h2);
    wait_sync();
    wr(8'h00, (~cfg & spicc_pkg::CTRL_A_WMASK) | 32'h2);
    rd(8'h00, d);
    chk(d, cfg | 32'h2);
    sleep_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(gclk_run), 32'(m[1]));
    sleep_req <= m[1];
    woke = 1'b0;
    xfer(8'h5A ^ {6'h0, m}, b);
    xfer(8'h0F, ~b);
    rd(8'h10, d);
    chk(32'(d[spicc_pkg::OVF_BIT]), 32'(m[0]));
    rd(spicc_pkg::DATA_OFS, d);
    chk(d, {24'h0, b});
    rd(8'h10, d);
    chk(32'(d[spicc_pkg::OVF_BIT]), 32'h1);
    wr(8'h10, 32'h0000_0004);
    chk(32'(woke), 32'(m[1]));
    sleep_req <= 1'b0;
    wr(8'h00, cfg);
    wait_sync();
    rd(8'h00, d);
    chk(d, cfg);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    rd(8'h00, d);
    chk(d, spicc_pkg::CTRL_A_RESET);
    rd(8'h04, d);
    chk(d, 32'h0);
    for (int m = 0; m < 4; m++) run_mode(m[1:0]);
    wr(8'h00, spicc_pkg::CTRL_A_WMASK | 32'h1);
    rd(8'h00, d);
    chk(d, 32'h0000_0001);
    rd(spicc_pkg::SYNC_OFS, d);
    chk(32'(d[spicc_pkg::SYNC_SR_BIT]), 32'h1);
    wait_sync();
    rd(8'h00, d);
    chk(d, 32'h0);
    report_and_stop();
  end
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
